/* hdl/hart_rx_frame_monitor_pkg.sv */
/*
  Constants shared by the receive frame monitor and its gap timer.
  Assumes a 100 MHz logic clock and a 16-bit internal register port.
*/
package hart_rx_frame_monitor_pkg;

  localparam int CLK_PERIOD_NS = 10;
  // one character time on the line, least idle that counts as a gap
  localparam int GAP_TIME_NS = 9000000;
  localparam int CHAR_BITS = 11;
  // bit period rounded up so that 11 bits never fall short of 9 ms
  localparam int BIT_CYCLES_DFLT =
    (GAP_TIME_NS + CHAR_BITS * CLK_PERIOD_NS - 1) / (CHAR_BITS * CLK_PERIOD_NS);
  localparam int GAP_CNT_W = 24;

  localparam logic [7:0] ALERT_ADDR = 8'h80;
  localparam logic [15:0] ALERT_RESET = 16'h0020;

  localparam int PHASE_LSB = 13;
  localparam int END_BIT = 12;
  localparam int LEN_BIT = 11;
  localparam int CMD_BIT = 10;
  localparam int BEGIN_BIT = 9;
  localparam int LOW_W = 9;

  localparam logic [7:0] LEADIN_BYTE = 8'hFF;
  localparam int DELIM_LONG_BIT = 7;
  localparam int DELIM_EXT_HI = 6;
  localparam int DELIM_EXT_LO = 5;
  localparam logic [2:0] SHORT_ADDR_LEN = 3'h1;
  localparam logic [2:0] LONG_ADDR_LEN = 3'h5;
  localparam logic [1:0] MIN_LEADIN = 2'h2;

  typedef enum logic [2:0] {
    phase_leadin = 3'b000,
    phase_target_bytes = 3'b001,
    phase_extension_bytes = 3'b010,
    phase_request_byte = 3'b011,
    phase_length_byte = 3'b100,
    phase_payload = 3'b101,
    phase_checksum = 3'b110
  } frame_tracker_phase_t;

endpackage

/* hdl/gap_timer.sv */
/*
  Idle timer between received characters.
  Assumes i_line_idle is already synchronised to i_mclk.
*/
`timescale 1ns/10ps
module gap_timer
  import hart_rx_frame_monitor_pkg::*;
#(
  parameter logic [GAP_CNT_W-1:0] LIMIT = GAP_CNT_W'(CHAR_BITS * BIT_CYCLES_DFLT)
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_line_idle,
  input wire logic i_char_done,
  output logic o_gap
);

  logic [GAP_CNT_W-1:0] idle_cnt;
  logic armed;

  // armed only between characters, so idle before the first byte is no gap
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed <= 1'b0;
    end else if (i_char_done) begin
      armed <= 1'b1;
    end else if (o_gap) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_cnt <= '0;
    end else if (i_char_done || !i_line_idle || !armed) begin
      idle_cnt <= '0;
    end else if (idle_cnt != LIMIT) begin
      idle_cnt <= idle_cnt + GAP_CNT_W'(1);
    end
  end

  // fires once when the idle run reaches a full character time
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gap <= 1'b0;
    end else begin
      o_gap <= armed && !i_char_done && i_line_idle &&
               (idle_cnt == LIMIT - GAP_CNT_W'(1));
    end
  end

endmodule

/* hdl/hart_rx_frame_monitor.sv */
/*
  Receive frame monitor for the modem UART: phase tracking and the
  sticky frame flags of the alert register.
  Assumes bytes arrive as one-cycle strobes from the UART receiver on
  i_mclk, and register accesses come from the serial-port decoder.
*/
//
// Behaviour
// - phase codes 000 to 011 for header phases
// - phase codes 100, 101, 110 for later phases
// - begin flag after two clean leadins plus delimiter
// - command flag at bit 10, gap suppresses
// - length flag at bit 11, gap suppresses
// - errored length byte withholds length flag
// - errors after the delimiter, except length byte, do not block length flag
// - end flag at bit 12 after checksum
// - no end flag when gap occurred
// - end flag despite errors after the delimiter, except length byte
// - gap when idle reaches 9 ms
// - character time is 11 bit periods
`timescale 1ns/10ps
module hart_rx_frame_monitor
  import hart_rx_frame_monitor_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_rxd,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_frame_err,
  input wire logic [LOW_W-1:0] i_modem_alert_low,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic [2:0] o_frame_tracker_phase,
  output logic o_gap_err
);

  localparam logic [GAP_CNT_W-1:0] GAP_LIMIT = GAP_CNT_W'(CHAR_BITS * BIT_CYCLES);

  frame_tracker_phase_t phase;
  frame_tracker_phase_t next_phase;
  logic rxd_meta;
  logic rxd_sync;
  logic gap;
  logic byte_err;
  logic [1:0] leadin_cnt;
  logic [2:0] hdr_left;
  logic [7:0] data_left;
  logic length_bad;
  logic message_begin_flag;
  logic header_to_command_flag;
  logic header_to_length_flag;
  logic message_end_flag;
  logic set_begin;
  logic set_cmd;
  logic set_len;
  logic set_end;
  logic wr_alert;
  logic [15:0] alert_word;

  // write-one-to-clear with the hardware set taking priority
  function automatic logic w1c_next(input logic cur, input logic set, input logic clr);
    w1c_next = set | (cur & ~clr);
  endfunction

  // line pin is asynchronous to the logic clock
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= i_rxd;
      rxd_sync <= rxd_meta;
    end
  end

  gap_timer #(
    .LIMIT(GAP_LIMIT)
  ) u_gap_timer (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_line_idle(rxd_sync),
    .i_char_done(i_rx_valid),
    .o_gap(gap)
  );

  assign byte_err = i_rx_parity_err | i_rx_frame_err;

  // a gap aborts the frame, so later flags of that frame cannot set
  always_comb begin
    next_phase = phase;
    set_begin = 1'b0;
    set_cmd = 1'b0;
    set_len = 1'b0;
    set_end = 1'b0;
    if (gap) begin
      next_phase = phase_leadin;
    end else if (i_rx_valid) begin
      unique case (phase)
        phase_leadin: begin
          if (!byte_err && i_rx_data != LEADIN_BYTE && leadin_cnt == MIN_LEADIN) begin
            set_begin = 1'b1;
            next_phase = phase_target_bytes;
          end
        end
        phase_target_bytes: begin
          if (hdr_left == SHORT_ADDR_LEN) begin
            next_phase = (data_left[1:0] != 2'h0) ? phase_extension_bytes
                                                  : phase_request_byte;
          end
        end
        phase_extension_bytes: begin
          if (data_left[1:0] == 2'h1) begin
            next_phase = phase_request_byte;
          end
        end
        phase_request_byte: begin
          set_cmd = 1'b1;
          next_phase = phase_length_byte;
        end
        phase_length_byte: begin
          set_len = !byte_err;
          next_phase = (i_rx_data == 8'h00) ? phase_checksum : phase_payload;
        end
        phase_payload: begin
          if (data_left == 8'h01) begin
            next_phase = phase_checksum;
          end
        end
        phase_checksum: begin
          set_end = !length_bad;
          next_phase = phase_leadin;
        end
        default: begin
          next_phase = phase_leadin;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= phase_leadin;
    end else begin
      phase <= next_phase;
    end
  end

  // leadin run: only clean leadin bytes count, saturating at the minimum
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      leadin_cnt <= 2'h0;
    end else if (gap || phase != phase_leadin) begin
      leadin_cnt <= 2'h0;
    end else if (i_rx_valid) begin
      if (byte_err || i_rx_data != LEADIN_BYTE) begin
        leadin_cnt <= 2'h0;
      end else if (leadin_cnt != MIN_LEADIN) begin
        leadin_cnt <= leadin_cnt + 2'h1;
      end
    end
  end

  // hdr_left counts address bytes; data_left holds extension then payload counts
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hdr_left <= 3'h0;
      data_left <= 8'h00;
    end else if (i_rx_valid && !gap) begin
      unique case (phase)
        phase_leadin: begin
          hdr_left <= i_rx_data[DELIM_LONG_BIT] ? LONG_ADDR_LEN : SHORT_ADDR_LEN;
          data_left <= {6'h00, i_rx_data[DELIM_EXT_HI:DELIM_EXT_LO]};
        end
        phase_target_bytes: begin
          hdr_left <= hdr_left - 3'h1;
        end
        phase_extension_bytes: begin
          data_left <= data_left - 8'h01;
        end
        phase_length_byte: begin
          data_left <= i_rx_data;
        end
        phase_payload: begin
          data_left <= data_left - 8'h01;
        end
        default: begin
          hdr_left <= hdr_left;
        end
      endcase
    end
  end

  // an errored length byte spoils the end flag of the same frame
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      length_bad <= 1'b0;
    end else if (i_rx_valid && phase == phase_length_byte) begin
      length_bad <= byte_err;
    end
  end

  assign wr_alert = i_reg_wr && (i_reg_addr == ALERT_ADDR);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      message_begin_flag <= 1'b0;
    end else begin
      message_begin_flag <= w1c_next(message_begin_flag, set_begin,
                                     wr_alert & i_reg_wdata[BEGIN_BIT]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      header_to_command_flag <= 1'b0;
    end else begin
      header_to_command_flag <= w1c_next(header_to_command_flag, set_cmd,
                                         wr_alert & i_reg_wdata[CMD_BIT]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      header_to_length_flag <= 1'b0;
    end else begin
      header_to_length_flag <= w1c_next(header_to_length_flag, set_len,
                                        wr_alert & i_reg_wdata[LEN_BIT]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      message_end_flag <= 1'b0;
    end else begin
      message_end_flag <= w1c_next(message_end_flag, set_end,
                                   wr_alert & i_reg_wdata[END_BIT]);
    end
  end

  // low bits belong to the rest of the modem and are only passed through
  always_comb begin
    alert_word = 16'h0000;
    alert_word[PHASE_LSB +: 3] = phase;
    alert_word[END_BIT] = message_end_flag;
    alert_word[LEN_BIT] = header_to_length_flag;
    alert_word[CMD_BIT] = header_to_command_flag;
    alert_word[BEGIN_BIT] = message_begin_flag;
    alert_word[LOW_W-1:0] = i_modem_alert_low;
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= ALERT_RESET;
    end else begin
      o_reg_rdata <= (i_reg_addr == ALERT_ADDR) ? alert_word : 16'h0000;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_frame_tracker_phase <= phase_leadin;
      o_gap_err <= 1'b0;
    end else begin
      o_frame_tracker_phase <= next_phase;
      o_gap_err <= gap;
    end
  end

endmodule

/* verification/hart_rx_frame_monitor_props.sv */
/* Port checker for the receive frame monitor.
   Bound to every monitor instance; sees its ports only. */
`timescale 1ns/10ps
module hart_rx_frame_monitor_chk
  import hart_rx_frame_monitor_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DFLT
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_rxd,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_parity_err,
  input wire logic i_rx_frame_err,
  input wire logic [LOW_W-1:0] i_modem_alert_low,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic [2:0] o_frame_tracker_phase,
  input wire logic o_gap_err
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  logic [23:0] idle;
  // pin-side idle count; sync delay only makes the design later
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle <= '0;
    end else if (i_rx_valid || !i_rxd) begin
      idle <= '0;
    end else if (idle != '1) begin
      idle <= idle + 24'h1;
    end
  end
  sequence alert_seen;
    $past(i_arst_n) && $past(i_reg_addr) == ALERT_ADDR;
  endsequence
  sequence end_clear;
    i_reg_wr && i_reg_addr == ALERT_ADDR && i_reg_wdata[END_BIT] && !i_rx_valid
    ##1 i_reg_addr == ALERT_ADDR && !i_rx_valid;
  endsequence
  property set_by_byte(b, logic [2:0] ph);
    $rose(o_reg_rdata[b]) && $past(i_reg_addr) == ALERT_ADDR && $past(i_reg_addr, 2) == ALERT_ADDR
    |-> $past(i_rx_valid, 2) && $past(o_frame_tracker_phase, 2) == ph;
  endproperty
  phase_code_a: assert property (o_frame_tracker_phase != 3'h7)
    else $error("undefined phase code");
  phase_mirror_a: assert property (alert_seen |-> o_reg_rdata[15:13] == $past(o_frame_tracker_phase))
    else $error("phase field differs");
  low_bits_a: assert property (alert_seen |-> o_reg_rdata[8:0] == $past(i_modem_alert_low))
    else $error("low bits differ");
  other_addr_a: assert property ($past(i_arst_n) && $past(i_reg_addr) != ALERT_ADDR |-> o_reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  phase_cause_a: assert property (!$stable(o_frame_tracker_phase) |-> $past(i_rx_valid) || o_frame_tracker_phase == phase_leadin)
    else $error("phase moved without byte");
  gap_idle_a: assert property (o_gap_err |-> idle >= 11 * BIT_CYCLES - 1)
    else $error("gap too early");
  end_clear_a: assert property (end_clear |=> !o_reg_rdata[END_BIT])
    else $error("end flag not cleared");
  end_set_a: assert property (set_by_byte(END_BIT, phase_checksum))
    else $error("end flag without check byte");
  len_set_a: assert property (set_by_byte(LEN_BIT, phase_length_byte))
    else $error("length flag without length byte");
  cmd_set_a: assert property (set_by_byte(CMD_BIT, phase_request_byte))
    else $error("command flag without command byte");
  begin_set_a: assert property (set_by_byte(BEGIN_BIT, phase_leadin))
    else $error("begin flag without delimiter");
endmodule
bind hart_rx_frame_monitor hart_rx_frame_monitor_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_i (.*);

/* verification/hart_byte_src.sv */
/* Byte source standing in for the modem receiver and its line.
   Called from the bench; everything changes at falling edges. */
`timescale 1ns/10ps
module hart_byte_src (
  input wire logic i_mclk,
  output logic o_rxd,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_perr,
  output logic o_ferr
);
  initial begin
    o_rxd = 1'b1;
    o_valid = 1'b0;
    o_data = 8'h00;
    o_perr = 1'b0;
    o_ferr = 1'b0;
  end
  task automatic send(input logic [7:0] b, input logic pe, input logic fe);
    @(negedge i_mclk);
    o_rxd <= 1'b0;
    repeat (8) @(negedge i_mclk);
    o_rxd <= 1'b1;
    o_valid <= 1'b1;
    o_data <= b;
    o_perr <= pe;
    o_ferr <= fe;
    @(negedge i_mclk);
    // released qualifiers show junk, not the last byte
    o_valid <= 1'b0;
    o_data <= ~b;
    o_perr <= ~pe;
    o_ferr <= ~fe;
  endtask
endmodule

/* verification/test_hart_rx_frame_monitor.sv */
/* Self-checking bench for the receive frame monitor.
   Assumes the byte source model and the bound checker. */
`timescale 1ns/10ps
module test_hart_rx_frame_monitor;
  import hart_rx_frame_monitor_pkg::*;
  logic i_mclk, i_arst_n, i_rxd, i_rx_valid, i_rx_parity_err, i_rx_frame_err, i_reg_wr, o_gap_err;
  logic [7:0] i_rx_data, i_reg_addr;
  logic [8:0] low;
  logic [15:0] i_reg_wdata, o_reg_rdata;
  logic [2:0] o_frame_tracker_phase;
  logic [16:0] notes[$];
  logic [16:0] nt;
  logic look;
  int num_errors, cmp_count, na, ne, h, ln;
  hart_rx_frame_monitor #(.BIT_CYCLES(4)) hart_rx_frame_monitor_i (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_rxd(i_rxd), .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data), .i_rx_parity_err(i_rx_parity_err), .i_rx_frame_err(i_rx_frame_err),
    .i_modem_alert_low(low), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_frame_tracker_phase(o_frame_tracker_phase), .o_gap_err(o_gap_err));
  hart_byte_src hart_byte_src_i (.i_mclk(i_mclk), .o_rxd(i_rxd), .o_valid(i_rx_valid),
    .o_data(i_rx_data), .o_perr(i_rx_parity_err), .o_ferr(i_rx_frame_err));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic note(input logic [16:0] n);
    notes.push_back(n);
    look = 1'b1;
    @(negedge i_mclk);
    look = 1'b0;
  endtask
  always @(posedge i_mclk) begin
    if (look) begin
      nt = notes.pop_front();
      chk(nt[16] ? "phase" : "alert", nt[16] ? {13'h0, o_frame_tracker_phase} : o_reg_rdata, nt[15:0]);
    end
  end
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_reg_addr = a;
    @(negedge i_mclk);
    note({1'b0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
  endtask
  // phase while waiting for byte q of a clean frame
  function automatic logic [2:0] nph(input int q);
    if (q < 3) return phase_leadin;
    if (q < 3 + na) return phase_target_bytes;
    if (q < h) return phase_extension_bytes;
    if (q == h) return phase_request_byte;
    if (q == h + 1) return phase_length_byte;
    if (q < h + 2 + ln) return phase_payload;
    if (q == h + 2 + ln) return phase_checksum;
    return phase_leadin;
  endfunction
  // bad: errored byte index; cut: last byte sent before the line idles
  task automatic frame(input logic [7:0] dl, input int len, input int bad, input int cut,
                       input logic [15:0] fl);
    logic [7:0] b;
    logic e;
    low = 9'($urandom);
    na = dl[DELIM_LONG_BIT] ? 5 : 1;
    ne = int'(dl[DELIM_EXT_HI:DELIM_EXT_LO]);
    h = 3 + na + ne;
    ln = len;
    if (cut < 0) cut = h + 2 + len;
    for (int p = 0; p <= cut; p++) begin
      b = p < 2 ? LEADIN_BYTE : p == 2 ? dl : p == h + 1 ? 8'(len) : 8'($urandom);
      e = 1'($urandom);
      hart_byte_src_i.send(b, p == bad && e, p == bad && !e);
      note({1'b1, 13'h0, nph(p + 1)});
    end
    for (int k = 0; k < 60 && o_gap_err !== 1'b1; k++) @(negedge i_mclk);
    chk("gap", {15'h0, o_gap_err}, 16'h0001);
    if (o_gap_err !== 1'b1) summarize();
    @(negedge i_mclk);
    note({1'b1, 16'h0000});
    // a write elsewhere must leave the set flags alone
    wr(8'h81, 16'hFFFF);
    rd(ALERT_ADDR, fl | {7'h0, low});
    wr(ALERT_ADDR, 16'hFFFF);
    rd(ALERT_ADDR, {7'h0, low});
    $display("frame test done, mismatches %0d", num_errors);
  endtask
  initial begin
    i_arst_n = 1'b0;
    i_reg_addr = ALERT_ADDR;
    i_reg_wr = 1'b0;
    i_reg_wdata = 16'h0000;
    look = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'h3ee2532d));
    low = 9'($urandom);
    repeat (8) @(negedge i_mclk);
    chk("reset word", o_reg_rdata, ALERT_RESET);
    i_arst_n = 1'b1;
    frame(8'h02, 2, -1, -1, 16'h1E00);
    frame(8'hA2, 0, 3, -1, 16'h1E00);
    frame(8'h02, 1, 5, -1, 16'h0600);
    frame(8'h02, 1, -1, 3, 16'h0200);
    wr(8'h81, 16'hFFFF);
    rd(8'h81, 16'h0000);
    rd(ALERT_ADDR, {7'h0, low});
    $display("address test done, mismatches %0d", num_errors);
    summarize();
  end
endmodule
